// ==== dv/conv_ctrl_chk.sv ====
// Port assertions for the converter control glue.
// Assumes a bind onto adc_clock_trigger_select.
`timescale 1ns/1ps
module conv_ctrl_chk
  import conv_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire trig_in_t trig_in,
  input wire logic deep_stop_mode,
  input wire logic hw_trigger,
  input wire logic [4:0] selected_channel,
  input wire logic temp_sensor_channel,
  input wire logic bandgap_channel,
  input wire logic conv_done
);
  // ==========================================
  // Port relations
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_temp_decode: assert property (temp_sensor_channel == (selected_channel == 5'h16))
    else $error("temperature channel decode wrong");
  a_bandgap_decode: assert property (bandgap_channel == (selected_channel == 5'h17))
    else $error("bandgap channel decode wrong");
  a_trig_single: assert property (hw_trigger |=> !hw_trigger)
    else $error("trigger pulse longer than one cycle");
  a_done_single: assert property (conv_done |=> !conv_done)
    else $error("done pulse longer than one cycle");
  a_stop_rtc_only: assert property (hw_trigger && $past(deep_stop_mode) |-> $past(trig_in.rtc_ovf))
    else $error("trigger in deep stop without overflow");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##[0:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_read_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready not inverse of valid");
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the converter control glue.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "conv_ctrl_regs.svh"
module testbench import conv_ctrl_pkg::*;;
  // ==========================================
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, wait_mode = 1'b0, deep_stop_mode = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, fire = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [11:0] level = 12'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic local_async_conv_clock, ext_osc_output, conversion_clock, hw_trigger;
  logic temp_sensor_channel, bandgap_channel, conv_done;
  logic [4:0] selected_channel;
  logic [11:0] analog_sample, conv_result;
  trig_in_t trig_in;
  int miscompares = 0;
  int check_count = 0;

  always #10 aclk = ~aclk;

  trig_src_model partner (.aclk, .fire, .level, .trig_in, .analog_sample, .ext_osc_output,
    .local_async_conv_clock);
  adc_clock_trigger_select dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .local_async_conv_clock, .ext_osc_output, .unused_clk('0),
    .trig_in, .wait_mode, .deep_stop_mode, .analog_sample, .conversion_clock, .hw_trigger,
    .selected_channel, .temp_sensor_channel, .bandgap_channel, .conv_result, .conv_done);

  // ==========================================
  // Helpers
  task automatic results();
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, 32'h0);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, 32'h0);
  endtask

  task automatic fire_wait(input logic [3:0] b, output int n);
    @(posedge aclk);
    fire <= b;
    @(posedge aclk);
    fire <= 4'h0;
    n = 0;
    // Look mid-cycle so the one-cycle trigger pulse is seen while it stands
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (!hw_trigger && n < 40);
  endtask

  task automatic convert(input logic [4:0] ch, input logic [11:0] lv, output logic [11:0] r);
    int n;
    wr(`OFF_CHAN_CFG, {27'h0, ch});
    level <= lv;
    fire_wait(4'h4, n);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      #1;
    end
    while (!conv_done && n < 3000);
    r = conv_result;
  endtask

  task automatic cnt(input logic [31:0] cfg, output int n);
    wr(`OFF_CLK_CFG, cfg);
    repeat (16) @(posedge aclk);
    n = 0;
    repeat (64)
    begin
      @(posedge aclk);
      #1;
      n += conversion_clock;
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    rd(`OFF_CLK_CFG, `CLK_CFG_RST);
    rd(`OFF_TRIG_CFG, `TRIG_CFG_RST);
    rd(`OFF_CHAN_CFG, `CHAN_CFG_RST);
    wr(`OFF_STATUS, 32'hffff_ffff);
    wr(`OFF_CHAN_CFG, 32'h0000_0009);
    rd(`OFF_CHAN_CFG, 32'h0000_0009);
  endtask

  task automatic t_chan();
    logic [4:0] codes[4] = '{5'h16, 5'h17, 5'h05, 5'h12};
    foreach (codes[i])
    begin
      wr(`OFF_CHAN_CFG, {27'h0, codes[i]});
      chk(selected_channel, codes[i]);
      chk(temp_sensor_channel, codes[i] == `CHAN_TEMP);
      chk(bandgap_channel, codes[i] == `CHAN_BANDGAP);
    end
  endtask

  task automatic t_trig();
    int n;
    logic [11:0] r;
    for (int s = 0; s < 4; s++)
    begin
      wait_mode <= s[0];
      wr(`OFF_TRIG_CFG, {16'h0, 8'h03, 5'h0, 1'b1, s[1:0]});
      fire_wait(4'h8 >> s, n);
      chk(n, s < 2 ? 1 : 4);
      convert(5'h12, 12'h0, r);
    end
    wait_mode <= 1'b0;
    wr(`OFF_TRIG_CFG, 32'h0000_0001);
    fire_wait(4'h4, n);
    chk(n, 40);
  endtask

  task automatic t_conv();
    logic [11:0] r;
    wr(`OFF_TRIG_CFG, 32'h0000_0005);
    convert(5'h05, 12'habc, r);
    chk(r, 12'habc);
    convert(5'h12, 12'h123, r);
    chk(r, 12'hfff);
    wr(`OFF_CLK_CFG, 32'h0000_0018);
    convert(`CHAN_BANDGAP, 12'h3a5, r);
    chk(r, 12'h3a5);
    convert(`CHAN_TEMP, 12'h5c3, r);
    chk(r, 12'h5c3);
    wr(`OFF_CLK_CFG, 32'h0);
  endtask

  task automatic t_stop();
    int n;
    deep_stop_mode <= 1'b1;
    wr(`OFF_TRIG_CFG, 32'h0000_0004);
    fire_wait(4'h8, n);
    chk(n, 40);
    wr(`OFF_TRIG_CFG, 32'h0000_0306);
    fire_wait(4'h2, n);
    chk(n, 40);
    wr(`OFF_TRIG_CFG, 32'h0000_0005);
    fire_wait(4'h4, n);
    chk(n, 1);
    deep_stop_mode <= 1'b0;
    repeat (40) @(posedge aclk);
  endtask

  task automatic t_clk();
    int n;
    cnt(32'h0, n);
    chk(n, 64);
    cnt(32'h8, n);
    chk(n, 16);
    cnt(32'h1, n);
    chk(n, 32);
    cnt(32'h3, n);
    chk(n > 0, 1);
    wait_mode <= 1'b1;
    cnt(32'h2, n);
    chk(n > 0, 1);
    deep_stop_mode <= 1'b1;
    cnt(32'h2, n);
    chk(n, 0);
  endtask

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_chan();
    t_trig();
    t_conv();
    t_stop();
    t_clk();
    results();
  end

  initial
  begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    results();
  end
endmodule

bind adc_clock_trigger_select conv_ctrl_chk chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .trig_in, .deep_stop_mode, .hw_trigger, .selected_channel,
  .temp_sensor_channel, .bandgap_channel, .conv_done);

// ==== dv/trig_src_model.sv ====
// Model of the timer trigger sources, oscillator and analog input.
// Assumes fire bits change just after a clock edge.
`timescale 1ns/1ps
module trig_src_model
  import conv_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic [3:0] fire,
  input wire logic [11:0] level,
  output trig_in_t trig_in,
  output logic [11:0] analog_sample,
  output logic ext_osc_output,
  output logic local_async_conv_clock
);
  // ==========================================
  // Sources
  logic [1:0] div = 2'h0;
  assign trig_in = fire;
  assign analog_sample = level;
  always_ff @(posedge aclk)
    div <= div + 2'h1;
  // Crystal and local clock run free, also in wait
  assign ext_osc_output = div[0];
  assign local_async_conv_clock = div[1];
endmodule

// ==== verilog/adc_clock_trigger_select.sv ====
// Converter clock and trigger selection glue with an AXI4-Lite register slave.
// Assumes clock sources arrive as levels sampled on aclk and triggers as aclk pulses.
//
// Notes on behaviour
// - Each conversion yields a 12-bit result for the selected channel.
// - Clock source mux offers bus, bus halved, local async, alternate clock.
// - Alternate clock input comes from the external oscillator output.
// - Selected source is divided by two to the power of the divide field to form conversion clock.
// - Alternate clock keeps running in wait mode.
// - Alternate clock is unavailable as conversion clock in deep stop.
// - Hardware trigger picks one of four timer-derived sources.
// - Six-channel timer triggers pass through an 8-bit programmable delay.
// - All triggers work in run and wait; only real-time overflow in deep stop.
// - Reserved channel still converts; result is forced to all ones (12'hfff).
// - Channel code 22 routes the temperature sensor.
// - Channel code 23 routes the bandgap reference.
// - The delay is an 8-bit counter between six-channel timer triggers and converter trigger.
`timescale 1ns/1ps
`include "conv_ctrl_regs.svh"

module adc_clock_trigger_select
  import conv_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic local_async_conv_clock,
  input wire logic ext_osc_output,
  input wire clk_in_t unused_clk,
  input wire trig_in_t trig_in,
  input wire logic wait_mode,
  input wire logic deep_stop_mode,
  input wire logic [11:0] analog_sample,
  output logic conversion_clock,
  output logic hw_trigger,
  output logic [4:0] selected_channel,
  output logic temp_sensor_channel,
  output logic bandgap_channel,
  output logic [11:0] conv_result,
  output logic conv_done
);

  // ==========================================================
  // Register state
  logic [31:0] clk_cfg, next_clk_cfg;
  logic [31:0] trig_cfg, next_trig_cfg;
  logic [31:0] chan_cfg, next_chan_cfg;
  logic [3:0] waddr, next_waddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic have_aw, next_have_aw;
  logic have_w, next_have_w;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [31:0] status_word;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb
  begin
    next_clk_cfg = clk_cfg;
    next_trig_cfg = trig_cfg;
    next_chan_cfg = chan_cfg;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_have_aw = have_aw;
    next_have_w = have_w;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && !have_aw)
    begin
      next_have_aw = 1'b1;
      next_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !have_w)
    begin
      next_have_w = 1'b1;
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
    end
    if (have_aw && have_w && !bvalid)
    begin
      next_have_aw = 1'b0;
      next_have_w = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = 2'h0;
      unique case (waddr)
        `OFF_CLK_CFG: next_clk_cfg = merge(clk_cfg, wdata, wstrb) & 32'h0000_001f;
        `OFF_TRIG_CFG: next_trig_cfg = merge(trig_cfg, wdata, wstrb) & 32'h0000_ff07;
        `OFF_CHAN_CFG: next_chan_cfg = merge(chan_cfg, wdata, wstrb) & 32'h0000_001f;
        `OFF_STATUS: next_bresp = 2'h0;
        default: next_bresp = 2'h2;
      endcase
    end
    if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp = 2'h0;
      unique case (s_axi_araddr)
        `OFF_CLK_CFG: next_rdata = clk_cfg;
        `OFF_TRIG_CFG: next_rdata = trig_cfg;
        `OFF_CHAN_CFG: next_rdata = chan_cfg;
        `OFF_STATUS: next_rdata = status_word;
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'h2;
        end
      endcase
    end
    else if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_cfg <= `CLK_CFG_RST;
      trig_cfg <= `TRIG_CFG_RST;
      chan_cfg <= `CHAN_CFG_RST;
      waddr <= 4'h0;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end
    else
    begin
      clk_cfg <= next_clk_cfg;
      trig_cfg <= next_trig_cfg;
      chan_cfg <= next_chan_cfg;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      have_aw <= next_have_aw;
      have_w <= next_have_w;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_awready = !have_aw;
  assign s_axi_wready = !have_w;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // ==========================================================
  // Conversion clock selection and divider
  clk_src_t clk_src;
  logic [2:0] div_field;
  logic alternate_conv_clock;
  logic src_level, src_prev, next_src_prev;
  logic src_edge, half_tog, next_half_tog;
  logic [7:0] div_cnt, next_div_cnt;
  logic [7:0] div_ratio;
  logic conv_clk_en, next_conv_clk_en;
  logic alt_blocked;

  assign clk_src = clk_src_t'(clk_cfg[`CLK_SRC_LSB +: 2]);
  assign div_field = clk_cfg[`CLK_DIV_LSB +: 3];
  assign alternate_conv_clock = ext_osc_output;
  assign alt_blocked = deep_stop_mode && (clk_src == clk_alternate);
  assign div_ratio = 8'h01 << div_field;

  always_comb
  begin
    unique case (clk_src)
      clk_bus: src_level = half_tog;
      clk_bus_half: src_level = half_tog;
      clk_alternate: src_level = alternate_conv_clock;
      clk_local_async: src_level = local_async_conv_clock;
    endcase
  end

  always_comb
  begin
    next_half_tog = !half_tog;
    next_src_prev = src_level;
    next_div_cnt = div_cnt;
    next_conv_clk_en = 1'b0;
    if (clk_src == clk_bus)
    begin
      src_edge = 1'b1;
    end
    else
    begin
      src_edge = src_level && !src_prev;
    end
    if (src_edge && !alt_blocked)
    begin
      if (div_cnt >= div_ratio - 8'h01)
      begin
        next_div_cnt = 8'h00;
        next_conv_clk_en = 1'b1;
      end
      else
      begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      half_tog <= 1'b0;
      src_prev <= 1'b0;
      div_cnt <= 8'h00;
      conv_clk_en <= 1'b0;
    end
    else
    begin
      half_tog <= next_half_tog;
      src_prev <= next_src_prev;
      div_cnt <= next_div_cnt;
      conv_clk_en <= next_conv_clk_en;
    end
  end

  assign conversion_clock = conv_clk_en;

  // ==========================================================
  // Trigger selection and delay counter
  trig_src_t trig_src;
  logic trig_en, raw_trig, timer_trig;
  logic [7:0] dly_cnt, next_dly_cnt;
  logic dly_busy, next_dly_busy;
  logic trig_pulse, next_trig_pulse;

  assign trig_src = trig_src_t'(trig_cfg[`TRIG_SRC_LSB +: 2]);
  assign trig_en = trig_cfg[`TRIG_EN_BIT];

  always_comb
  begin
    raw_trig = 1'b0;
    timer_trig = 1'b0;
    unique case (trig_src)
      trig_modulo_timer: raw_trig = trig_in.modulo_timer_zero_ovf && !deep_stop_mode;
      trig_rtc: raw_trig = trig_in.rtc_ovf;
      trig_timer_match: timer_trig = trig_in.six_channel_timer_match && !deep_stop_mode;
      trig_timer_init: timer_trig = trig_in.six_channel_timer_init && !deep_stop_mode;
    endcase
  end

  always_comb
  begin
    next_dly_cnt = dly_cnt;
    next_dly_busy = dly_busy;
    next_trig_pulse = 1'b0;
    if (!trig_en || deep_stop_mode && dly_busy)
    begin
      next_dly_busy = 1'b0;
    end
    else if (raw_trig)
    begin
      next_trig_pulse = 1'b1;
    end
    else if (timer_trig)
    begin
      next_dly_cnt = trig_cfg[`TRIG_DLY_LSB +: 8];
      next_dly_busy = (trig_cfg[`TRIG_DLY_LSB +: 8] != 8'h00);
      next_trig_pulse = (trig_cfg[`TRIG_DLY_LSB +: 8] == 8'h00);
    end
    else if (dly_busy)
    begin
      next_dly_cnt = dly_cnt - 8'h01;
      if (dly_cnt == 8'h01)
      begin
        next_dly_busy = 1'b0;
        next_trig_pulse = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dly_cnt <= 8'h00;
      dly_busy <= 1'b0;
      trig_pulse <= 1'b0;
    end
    else
    begin
      dly_cnt <= next_dly_cnt;
      dly_busy <= next_dly_busy;
      trig_pulse <= next_trig_pulse;
    end
  end

  assign hw_trigger = trig_pulse;

  // ==========================================================
  // Channel routing and conversion sequencing
  logic [4:0] busy_cnt, next_busy_cnt;
  logic [11:0] result, next_result;
  logic done, next_done;
  logic chan_reserved;

  assign selected_channel = chan_cfg[`CHAN_LSB +: 5];
  assign temp_sensor_channel = (selected_channel == `CHAN_TEMP);
  assign bandgap_channel = (selected_channel == `CHAN_BANDGAP);
  assign chan_reserved = (selected_channel > `CHAN_MAX_PIN) && !temp_sensor_channel
                         && !bandgap_channel;

  always_comb
  begin
    next_busy_cnt = busy_cnt;
    next_result = result;
    next_done = 1'b0;
    if (busy_cnt == 5'h00)
    begin
      if (trig_pulse)
      begin
        next_busy_cnt = `CONV_CYCLES;
      end
    end
    else if (conv_clk_en)
    begin
      next_busy_cnt = busy_cnt - 5'h01;
      if (busy_cnt == 5'h01)
      begin
        next_result = chan_reserved ? 12'hfff : analog_sample;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_cnt <= 5'h00;
      result <= 12'h000;
      done <= 1'b0;
    end
    else
    begin
      busy_cnt <= next_busy_cnt;
      result <= next_result;
      done <= next_done;
    end
  end

  assign conv_result = result;
  assign conv_done = done;
  assign status_word = {15'h0000, dly_busy, dly_cnt, 3'h0, busy_cnt != 5'h00, result[11:8]}
                       | {20'h00000, result};

endmodule

// ==== verilog/conv_ctrl_pkg.sv ====
// Types for the converter control glue.
// Assumes the constants header sits beside it.
package conv_ctrl_pkg;
  `include "conv_ctrl_regs.svh"

  typedef enum logic [1:0]
  {
    clk_bus = 2'h0,
    clk_bus_half = 2'h1,
    clk_alternate = 2'h2,
    clk_local_async = 2'h3
  } clk_src_t;

  typedef enum logic [1:0]
  {
    trig_modulo_timer = 2'h0,
    trig_rtc = 2'h1,
    trig_timer_match = 2'h2,
    trig_timer_init = 2'h3
  } trig_src_t;

  typedef struct packed
  {
    logic modulo_timer_zero_ovf;
    logic rtc_ovf;
    logic six_channel_timer_match;
    logic six_channel_timer_init;
  } trig_in_t;

  typedef struct packed
  {
    logic bus;
    logic local_async_conv_clock;
    logic alternate_conv_clock;
  } clk_in_t;
endpackage

// ==== verilog/conv_ctrl_regs.svh ====
// Offsets, field positions, reset values and counts for the converter control glue.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH

// Register byte offsets
`define OFF_CLK_CFG 4'h0
`define OFF_TRIG_CFG 4'h4
`define OFF_CHAN_CFG 4'h8
`define OFF_STATUS 4'hc

// Clock configuration fields
`define CLK_SRC_LSB 0
`define CLK_DIV_LSB 2
`define CLK_CFG_RST 32'h0000_0000

// Trigger configuration fields
`define TRIG_SRC_LSB 0
`define TRIG_EN_BIT 2
`define TRIG_DLY_LSB 8
`define TRIG_CFG_RST 32'h0000_0000

// Channel configuration fields
`define CHAN_LSB 0
`define CHAN_CFG_RST 32'h0000_0000
`define CHAN_TEMP 5'h16
`define CHAN_BANDGAP 5'h17
`define CHAN_MAX_PIN 5'h0f

// Conversion timing
`define CONV_CYCLES 5'h0e

`endif
